/* rtl/bus_pins.v */
// external address, lane-select, 16-bit data and parity pins of the core bus
// assumes cycle framing (ready, hold) comes from the bus controller logic; the start of a cycle is decided here
//
// Overview of operation
// - everything timed on rising core clock
// - word address plus four lane selects
// - upper address lines accept invalidation addresses
// - address lines released during hold
// - lane selects active low, floated during hold
// - lane selects 0 and 1 qualify one byte each; selects 2 and 3 qualify no byte
// - low byte on bits 7..0
// - write data driven from second clock on
// - parity per lane driven with write data
// - read parity never alters delivered data
// - parity lines driven from second write clock
// - parity error reported clock after ready
module bus_pins (
  // clock and reset
  input  wire        core_clk_in,
  input  wire        rst_in,
  // core request side
  input  wire        req_valid_in,
  output wire        req_ready_out,
  input  wire        req_write_in,
  input  wire [29:0] req_word_in,
  input  wire [3:0]  req_lanes_n_in,
  input  wire [15:0] req_wdata_in,
  // cycle framing from the bus controller logic
  input  wire        ready_n_in,
  input  wire        hold_in,
  // read data to core
  output reg         rd_valid_out,
  output reg  [15:0] rd_data_out,
  // invalidation address to the cache
  input  wire        inval_strobe_in,
  output reg         inval_valid_out,
  output reg  [27:0] inval_word_out,
  // address and lane-select pins
  input  wire [27:0] word_address_lines_in,
  output reg  [29:0] word_address_lines_out,
  output reg         word_address_lines_oe_n_out,
  output reg  [3:0]  lane_select_n_out,
  output reg         lane_select_oe_n_out,
  // data and parity pins
  input  wire [15:0] data_lines_in,
  output reg  [15:0] data_lines_out,
  output reg         data_lines_oe_n_out,
  input  wire        parity_high_lane_in,
  input  wire        parity_low_lane_in,
  output reg         parity_high_lane_out,
  output reg         parity_low_lane_out,
  output reg         parity_oe_n_out,
  // check status
  output reg         parity_error_n_out
);
`include "addr_parity_defs.vh"

  localparam ST_IDLE  = `BUS_PHASE_IDLE;
  localparam ST_FIRST = `BUS_PHASE_FIRST;
  localparam ST_DATA  = `BUS_PHASE_DATA;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         write_q;
  reg  [3:0]  lanes_q;
  reg  [15:0] wdata_q;
  wire        buf_valid;
  wire        buf_take;
  wire [50:0] buf_data;
  wire [1:0]  gen_par;
  wire [1:0]  chk_err;
  wire        ready;

  // lanes 0 and 1 active with a parity error, the two lanes of a 16-bit transfer
  function lanes_hit;
    input [3:0] lanes_n;
    input [1:0] err;
    begin
      lanes_hit = (err[0] & ~lanes_n[0]) | (err[1] & ~lanes_n[1]);
    end
  endfunction

  // a held bus stalls the core, losing no queued request
  skid_buffer #(.WIDTH(51)) u_buf (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (req_valid_in),
    .in_ready_out  (req_ready_out),
    .in_data_in    ({req_write_in, req_word_in, req_lanes_n_in, req_wdata_in}),
    .out_valid_out (buf_valid),
    .out_ready_in  (buf_take),
    .out_data_out  (buf_data)
  );

  // parity comes from the latched write word so it lines up with the data launch
  lane_parity u_par_lo (
    .byte_in    (wdata_q[7:0]),
    .parity_in  (parity_low_lane_in),
    .parity_out (gen_par[0]),
    .error_out  ()
  );

  lane_parity u_par_hi (
    .byte_in    (wdata_q[15:8]),
    .parity_in  (parity_high_lane_in),
    .parity_out (gen_par[1]),
    .error_out  ()
  );

  // checkers look at the sampled read bytes
  lane_parity u_chk_lo (
    .byte_in    (data_lines_in[7:0]),
    .parity_in  (parity_low_lane_in),
    .parity_out (),
    .error_out  (chk_err[0])
  );

  lane_parity u_chk_hi (
    .byte_in    (data_lines_in[15:8]),
    .parity_in  (parity_high_lane_in),
    .parity_out (),
    .error_out  (chk_err[1])
  );

  assign ready    = ~ready_n_in;
  assign buf_take = (state_q == ST_IDLE) & ~hold_in;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (buf_valid & ~hold_in) state_d = ST_FIRST;
      ST_FIRST: if (ready) state_d = ST_IDLE; else state_d = ST_DATA;
      ST_DATA:  if (ready) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q                     <= ST_IDLE;
      write_q                     <= 1'b0;
      lanes_q                     <= `BUS_LANES_RESET;
      wdata_q                     <= 16'h0000;
      rd_valid_out                <= 1'b0;
      rd_data_out                 <= 16'h0000;
      inval_valid_out             <= 1'b0;
      inval_word_out              <= 28'h0000000;
      word_address_lines_out      <= 30'h00000000;
      word_address_lines_oe_n_out <= 1'b1;
      lane_select_n_out           <= `BUS_LANES_RESET;
      lane_select_oe_n_out        <= 1'b1;
      data_lines_out              <= 16'h0000;
      data_lines_oe_n_out         <= 1'b1;
      parity_high_lane_out        <= 1'b0;
      parity_low_lane_out         <= 1'b0;
      parity_oe_n_out             <= 1'b1;
      parity_error_n_out          <= `BUS_ERR_IDLE;
    end else begin
      state_q <= state_d;
      // address and lane selects float whenever the bus is held
      word_address_lines_oe_n_out <= hold_in;
      lane_select_oe_n_out        <= hold_in;
      if (buf_take & buf_valid) begin
        write_q                <= buf_data[50];
        word_address_lines_out <= buf_data[49:20];
        lanes_q                <= buf_data[19:16];
        lane_select_n_out      <= buf_data[19:16];
        wdata_q                <= buf_data[15:0];
      end
      // write data and parity from the second clock to the end of the cycle
      if (state_q == ST_FIRST && write_q && !ready) begin
        data_lines_out      <= wdata_q;
        data_lines_oe_n_out <= 1'b0;
        parity_oe_n_out     <= 1'b0;
      end else if (state_q != ST_DATA || ready) begin
        data_lines_oe_n_out <= 1'b1;
        parity_oe_n_out     <= 1'b1;
      end
      parity_low_lane_out  <= gen_par[0];
      parity_high_lane_out <= gen_par[1];
      // read data passes through untouched by parity
      rd_valid_out <= (state_q != ST_IDLE) & ~write_q & ready;
      if ((state_q != ST_IDLE) & ~write_q & ready)
        rd_data_out <= data_lines_in;
      // status for enabled lanes only, in the clock after ready
      if ((state_q != ST_IDLE) & ~write_q & ready)
        parity_error_n_out <= ~lanes_hit(lanes_q, chk_err);
      else
        parity_error_n_out <= `BUS_ERR_IDLE;
      // snooped address accepted only while hold_in is high
      inval_valid_out <= inval_strobe_in & hold_in;
      if (inval_strobe_in & hold_in)
        inval_word_out <= word_address_lines_in;
    end
  end
endmodule // bus_pins

/* rtl/addr_parity_defs.vh */
// constants for the external address, lane-select, data and parity pins
// assumes inclusion by bare name from the design files
`ifndef ADDR_PARITY_DEFS_VH
`define ADDR_PARITY_DEFS_VH
`define BUS_WORD_HI        29
`define BUS_INVAL_HI       27
`define BUS_LANES_RESET    4'hf
`define BUS_PHASE_IDLE     2'h0
`define BUS_PHASE_FIRST    2'h1
`define BUS_PHASE_DATA     2'h2
`define BUS_PHASE_CHECK    2'h3
`define BUS_ERR_IDLE       1'h1
`endif

/* rtl/lane_parity.v */
// even-parity generator and checker for one 8-bit byte lane
// assumes nothing; purely combinational
module lane_parity (
  // lane data and sampled parity
  input  wire [7:0] byte_in,
  input  wire       parity_in,
  // generated parity and check result
  output wire       parity_out,
  output wire       error_out
);
  assign parity_out = ^byte_in;
  assign error_out  = (^byte_in) ^ parity_in;
endmodule // lane_parity

/* rtl/skid_buffer.v */
// two-entry buffer with valid/ready on both sides
// assumes a single clock and async active-high reset
module skid_buffer #(
  parameter WIDTH = 48
) (
  // clock and reset
  input  wire             core_clk_in,
  input  wire             rst_in,
  // fill side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // drain side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_q;
  reg             rd_q;
  reg [1:0]       count_q;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_q != 2'h2);
  assign out_valid_out = (count_q != 2'h0);
  assign out_data_out  = mem_q[rd_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage has no reset: only valid entries are ever read
  always @(posedge core_clk_in) begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end
endmodule // skid_buffer

/* verif/bus_pins_monitor.sv */
// assertions on the pin side of bus_pins
// assumes one clock, bound into every bus_pins instance
module bus_pins_monitor (
  // clock, reset, framing
  input logic        core_clk_in,
  input logic        rst_in,
  input logic        ready_n_in,
  input logic        hold_in,
  // toward the core
  input logic        rd_valid_out,
  input logic [15:0] rd_data_out,
  input logic        inval_valid_out,
  input logic [27:0] inval_word_out,
  // pins
  input logic [27:0] word_address_lines_in,
  input logic        word_address_lines_oe_n_out,
  input logic [3:0]  lane_select_n_out,
  input logic        lane_select_oe_n_out,
  input logic [15:0] data_lines_in,
  input logic [15:0] data_lines_out,
  input logic        data_lines_oe_n_out,
  input logic        parity_high_lane_in,
  input logic        parity_low_lane_in,
  input logic        parity_high_lane_out,
  input logic        parity_low_lane_out,
  input logic        parity_oe_n_out,
  input logic        parity_error_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // odd ones count in an enabled lane
  wire bad = (!lane_select_n_out[0] && ^{data_lines_in[7:0], parity_low_lane_in})
    || (!lane_select_n_out[1] && ^{data_lines_in[15:8], parity_high_lane_in});
  addr_release_a: assert property (hold_in |=> word_address_lines_oe_n_out)
    else $error("address lines driven during hold");
  lane_release_a: assert property (hold_in |=> lane_select_oe_n_out)
    else $error("lane selects driven during hold");
  low_parity_a: assert property (!parity_oe_n_out |-> parity_low_lane_out == ^data_lines_out[7:0])
    else $error("low lane parity wrong");
  high_parity_a: assert property (!parity_oe_n_out |-> parity_high_lane_out == ^data_lines_out[15:8])
    else $error("high lane parity wrong");
  parity_timing_a: assert property (parity_oe_n_out == data_lines_oe_n_out)
    else $error("parity not driven with data");
  data_second_a: assert property ($fell(data_lines_oe_n_out) |-> $past(ready_n_in))
    else $error("data driven in a cycle already ended");
  err_value_a: assert property (rd_valid_out |-> parity_error_n_out == !$past(bad))
    else $error("parity status wrong");
  err_moment_a: assert property (!parity_error_n_out |-> rd_valid_out)
    else $error("parity status outside read answer");
  read_data_a: assert property (rd_valid_out |-> rd_data_out == $past(data_lines_in))
    else $error("read data altered");
  inval_addr_a: assert property (inval_valid_out |-> inval_word_out == $past(word_address_lines_in))
    else $error("invalidation address wrong");
  cover property (!parity_error_n_out);
  cover property (!data_lines_oe_n_out && !ready_n_in);
  cover property (inval_valid_out);
endmodule // bus_pins_monitor

bind bus_pins bus_pins_monitor mon (.*);

/* verif/bus_far_end.sv */
// behavioural memory controller at the far side of bus_pins
// assumes the bench gives wait count, read data and a parity fault per cycle
module bus_far_end (
  input  logic        core_clk_in,
  input  logic        rst_in,
  input  logic        taken_in,
  input  logic        hold_in,
  input  logic [1:0]  waits_in,
  input  logic [15:0] rdata_in,
  input  logic        bad_in,
  input  logic [15:0] dev_data_in,
  input  logic        dev_oe_n_in,
  input  logic [3:0]  lanes_n_in,
  output logic        ready_n_out,
  output logic [15:0] wire_data_out,
  output logic        par_low_out,
  output logic        par_high_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy_q;
  logic [2:0] queued_q;
  logic [1:0] cnt_q;
  logic [15:0] drv_q;
  // mirrors the device's start condition, it has no start strobe to watch
  wire start = !busy_q && queued_q != 3'h0 && !hold_in;
  // ready pulses once the bench's wait count has run out
  wire nxt = start ? waits_in == 2'h0 : busy_q && ready_n_out && cnt_q + 2'h1 == waits_in;
  assign wire_data_out = dev_oe_n_in ? drv_q : dev_data_in;
  assign par_low_out = ^wire_data_out[7:0] ^ bad_in;
  // high fault only where the selects leave that lane off; no fills, so the selects apply
  assign par_high_out = ^wire_data_out[15:8] ^ (bad_in && lanes_n_in[1]);
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {busy_q, cnt_q, queued_q, drv_q, ready_n_out} <= {22'h0, 1'h1};
    end else begin
      queued_q <= queued_q + {2'h0, taken_in} - {2'h0, start};
      if (start) begin
        busy_q <= 1'h1;
        cnt_q <= 2'h0;
      end else if (busy_q && !ready_n_out) begin
        busy_q <= 1'h0;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
      ready_n_out <= !nxt;
      // released lines keep changing so no stale value reads back
      drv_q <= nxt ? rdata_in : ~drv_q;
    end
  end
endmodule // bus_far_end

/* verif/bus_pins_tb.sv */
// self-checking bench for bus_pins
// assumes bus_far_end as the far side and the bound monitor
module bus_pins_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0, hold_in = 0;
  logic inval_strobe_in = 0, bad = 0, prev_oe = 1;
  logic [29:0] req_word_in = 0;
  logic [3:0] req_lanes_n_in = 4'hf;
  logic [15:0] req_wdata_in = 0, rdata = 0;
  logic [27:0] word_address_lines_in = 0;
  logic [1:0] waits = 0;
  wire req_ready_out, ready_n_in, rd_valid_out, inval_valid_out, word_address_lines_oe_n_out;
  wire lane_select_oe_n_out, data_lines_oe_n_out, parity_high_lane_in, parity_low_lane_in;
  wire parity_high_lane_out, parity_low_lane_out, parity_oe_n_out, parity_error_n_out;
  wire [15:0] rd_data_out, data_lines_in, data_lines_out;
  wire [27:0] inval_word_out;
  wire [29:0] word_address_lines_out;
  wire [3:0] lane_select_n_out;
  int errors = 0, checks = 0, cyc = 0;
  logic [63:0] rq[$], wq[$], iq[$];
  always #10 core_clk_in = ~core_clk_in;
  bus_pins dut (.*);
  bus_far_end far (.core_clk_in, .rst_in, .taken_in(req_valid_in && req_ready_out), .hold_in,
    .waits_in(waits), .rdata_in(rdata), .bad_in(bad), .dev_data_in(data_lines_out),
    .dev_oe_n_in(data_lines_oe_n_out), .ready_n_out(ready_n_in), .wire_data_out(data_lines_in),
    .lanes_n_in(lane_select_n_out), .par_low_out(parity_low_lane_in),
    .par_high_out(parity_high_lane_in));
  task chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task req(input logic w, input logic [15:0] d);
    logic [29:0] a;
    logic [3:0] l;
    a = 30'($urandom);
    l = 4'($urandom);
    @(negedge core_clk_in);
    {req_valid_in, req_write_in, req_word_in, req_lanes_n_in, req_wdata_in} = {1'h1, w, a, l, d};
    if (w) wq.push_back({a, l, ^d[15:8], ^d[7:0], d});
    else rq.push_back({!(bad && !l[0]), rdata});
    while (!req_ready_out) @(negedge core_clk_in);
    @(negedge core_clk_in);
    req_valid_in = 0;
  endtask
  task drain;
    for (int i = 0; i < 80 && rq.size() + wq.size() + iq.size() > 0; i++) @(negedge core_clk_in);
    chk("pending", rq.size() + wq.size() + iq.size(), 0);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge core_clk_in) begin
    if (rd_valid_out) chk("read", {parity_error_n_out, rd_data_out}, rq.pop_front());
    if (!data_lines_oe_n_out && prev_oe) chk("write", {word_address_lines_out, lane_select_n_out,
      parity_high_lane_out, parity_low_lane_out, data_lines_out}, wq.pop_front());
    prev_oe = data_lines_oe_n_out;
    if (inval_valid_out) chk("inval", inval_word_out, iq.pop_front());
  end
  always @(posedge core_clk_in) if (++cyc == 3000) begin
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(56884));
    repeat (8) @(posedge core_clk_in);
    @(negedge core_clk_in) rst_in = 0;
    for (int i = 0; i < 8; i++) begin
      {bad, waits, rdata} = 19'($urandom);
      req(0, 16'h0);
      drain();
    end
    $display("reads done");
    {bad, waits} = 3'h3;
    // slow far side so the two-entry buffer fills and refuses
    repeat (6) req(1, 16'($urandom));
    drain();
    $display("writes done");
    hold_in = 1;
    req(0, 16'h0);
    chk("release", {word_address_lines_oe_n_out, lane_select_oe_n_out}, 2'h3);
    word_address_lines_in = 28'($urandom);
    iq.push_back(word_address_lines_in);
    inval_strobe_in = 1;
    @(negedge core_clk_in) inval_strobe_in = 0;
    repeat (5) @(negedge core_clk_in);
    chk("stalled", rq.size(), 1);
    hold_in = 0;
    drain();
    $display("hold done");
    complete_run();
  end
endmodule // bus_pins_tb
